//--- rtl/see_cfg.svh
`ifndef SEE_CFG_SVH
`define SEE_CFG_SVH

// ----------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------
`define SEE_TYPE_PREFIX 4'hA
`define SEE_PREFIX_MSB 7
`define SEE_PREFIX_LSB 4
`define SEE_SEL_MSB 3
`define SEE_SEL_LSB 1
`define SEE_RW_BIT 0
`define SEE_MASK_LARGE 8'hFF
`define SEE_MASK_SMALL 8'h7F

// ----------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------
`define SEE_ACK_SLOT 4'h8
`define SEE_ACK_DONE 4'h9
`define SEE_PAGE_LAST 4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SEE_CLK_MHZ 50
`define SEE_NV_WRITE_TIME_US 5000
`define SEE_NV_WRITE_CYCLES (`SEE_NV_WRITE_TIME_US * `SEE_CLK_MHZ)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEE_RST_PIN_HIGH 1'b1
`define SEE_RST_OE_N 1'b1

`endif

//--- rtl/see_pkg.sv
package see_pkg;

    // ----------------------------------------------------------------
    // Protocol states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WADDR,
        ST_WDATA,
        ST_RDATA
    } see_state_e;

    // ----------------------------------------------------------------
    // Array write port, array storage and link capture state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } see_mem_wr_s;

    typedef struct packed {
        logic [255:0][7:0] arr;
        logic [7:0] rd;
    } see_mem_s;

    typedef struct packed {
        logic bit_q;
    } see_link_s;

    // ----------------------------------------------------------------
    // Controller state
    // ----------------------------------------------------------------
    typedef struct packed {
        see_state_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic ackd;
        logic [7:0] addr;
        logic [7:0][7:0] page;
        logic [7:0] pmask;
        logic busy;
        logic [3:0] idx;
        logic [17:0] timer;
        logic oe_n;
        logic sda_val;
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic bit_s1;
        logic bit_s2;
        logic wp_s1;
        logic wp_s2;
        logic [2:0] hw_s1;
        logic [2:0] hw_s2;
        logic [1:0] dly;
        see_mem_wr_s wr;
    } see_top_s;

endpackage : see_pkg

//--- rtl/see_link_cap.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Bit capture on the serial clock
// ----------------------------------------------------------------
module see_link_cap (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic bit_o
);

    see_pkg::see_link_s q;
    see_pkg::see_link_s d;

    always_comb begin
        d = q;
        d.bit_q = sda_i;
    end

    always_ff @(posedge scl_i) begin
        q <= d;
    end

    assign bit_o = q.bit_q;

endmodule : see_link_cap

//--- rtl/see_mem.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Byte array with registered read
// ----------------------------------------------------------------
module see_mem (
    input wire logic ref_clk_i,
    input see_pkg::see_mem_wr_s wr_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o
);

    see_pkg::see_mem_s q;
    see_pkg::see_mem_s d;

    always_comb begin
        d = q;
        d.rd = q.arr[rd_addr_i];
        if (wr_i.en) begin
            d.arr[wr_i.addr] = wr_i.data;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        q <= d;
    end

    assign rd_data_o = q.rd;

endmodule : see_mem

//--- rtl/see_top.sv
`timescale 1ns/10ps
`include "see_cfg.svh"

module see_top #(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int NV_WRITE_CYCLES = `SEE_NV_WRITE_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [2:0] hw_address_select_i,
    input wire logic write_guard_pin_i,
    output logic busy_o
);

    see_pkg::see_top_s q;
    see_pkg::see_top_s d;

    logic link_bit;
    logic [7:0] rd_data;
    logic [7:0] mask;
    logic rise;
    logic fall;
    logic start_ev;
    logic stop_ev;
    logic bit_ev;
    logic dev_miss;

    // ----------------------------------------------------------------
    // Link domain capture and array
    // ----------------------------------------------------------------
    see_link_cap u_link (
        .scl_i(scl_i),
        .sda_i(sda_i),
        .bit_o(link_bit)
    );

    see_mem u_mem (
        .ref_clk_i(ref_clk_i),
        .wr_i(q.wr),
        .rd_addr_i(q.addr),
        .rd_data_o(rd_data)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;

        // ----------------------------------------------------------------
        // Pin synchronisers
        // ----------------------------------------------------------------
        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        d.scl_p = q.scl_s2;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_p = q.sda_s2;
        d.bit_s1 = link_bit;
        d.bit_s2 = q.bit_s1;
        d.wp_s1 = write_guard_pin_i;
        d.wp_s2 = q.wp_s1;
        d.hw_s1 = hw_address_select_i;
        d.hw_s2 = q.hw_s1;
        d.sda_val = 1'b0;
        d.wr = '0;
        mask = LARGE_VARIANT ? `SEE_MASK_LARGE : `SEE_MASK_SMALL;
        rise = q.scl_s2 & ~q.scl_p;
        fall = ~q.scl_s2 & q.scl_p;
        start_ev = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
        stop_ev = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
        d.dly = {q.dly[0], rise};
        bit_ev = q.dly[1];
        dev_miss = (q.sh[`SEE_PREFIX_MSB:`SEE_PREFIX_LSB] != `SEE_TYPE_PREFIX)
            || (q.sh[`SEE_SEL_MSB:`SEE_SEL_LSB] != q.hw_s2);

        // ----------------------------------------------------------------
        // Self-timed commit of the page buffer
        // ----------------------------------------------------------------
        if (q.busy) begin
            if (q.idx != `SEE_PAGE_LAST) begin
                d.wr.en = q.pmask[q.idx[2:0]];
                d.wr.addr = {q.addr[7:3], q.idx[2:0]} & mask;
                d.wr.data = q.page[q.idx[2:0]];
                d.idx = q.idx + 4'h1;
            end
            if (q.timer == 18'(NV_WRITE_CYCLES - 1)) begin
                d.busy = 1'b0;
                d.pmask = '0;
                d.timer = '0;
            end else begin
                d.timer = q.timer + 18'h0_0001;
            end
        end

        // ----------------------------------------------------------------
        // Bus protocol
        // ----------------------------------------------------------------
        if (start_ev) begin
            d.oe_n = 1'b1;
            d.cnt = '0;
            if (q.busy) begin
                d.st = see_pkg::ST_IDLE;
            end else begin
                d.st = see_pkg::ST_DEV;
                d.pmask = '0;
            end
        end else if (stop_ev) begin
            d.oe_n = 1'b1;
            d.st = see_pkg::ST_IDLE;
            if (!q.busy) begin
                if ((q.pmask != '0) && !q.wp_s2) begin
                    d.busy = 1'b1;
                    d.idx = '0;
                    d.timer = '0;
                end else begin
                    d.pmask = '0;
                end
            end
        end else if (q.st != see_pkg::ST_IDLE) begin
            if (bit_ev) begin
                if (q.st == see_pkg::ST_RDATA) begin
                    if (q.cnt == `SEE_ACK_DONE) begin
                        d.ackd = ~q.bit_s2;
                    end
                end else if (q.cnt < `SEE_ACK_SLOT) begin
                    d.sh = {q.sh[6:0], q.bit_s2};
                    d.cnt = q.cnt + 4'h1;
                end
            end else if (fall) begin
                if (q.st == see_pkg::ST_RDATA) begin
                    if (q.cnt < `SEE_ACK_SLOT) begin
                        d.oe_n = q.tx[7];
                        d.tx = {q.tx[6:0], 1'b0};
                        d.cnt = q.cnt + 4'h1;
                    end else if (q.cnt == `SEE_ACK_SLOT) begin
                        d.oe_n = 1'b1;
                        d.cnt = `SEE_ACK_DONE;
                        d.ackd = 1'b0;
                        d.addr = (q.addr + 8'h01) & mask;
                    end else if (q.ackd) begin
                        d.oe_n = rd_data[7];
                        d.tx = {rd_data[6:0], 1'b0};
                        d.cnt = 4'h1;
                        d.ackd = 1'b0;
                    end else begin
                        d.oe_n = 1'b1;
                        d.st = see_pkg::ST_IDLE;
                    end
                end else if (q.cnt == `SEE_ACK_SLOT) begin
                    if ((q.st == see_pkg::ST_DEV) && dev_miss) begin
                        d.st = see_pkg::ST_IDLE;
                    end else begin
                        d.oe_n = 1'b0;
                        d.cnt = `SEE_ACK_DONE;
                    end
                end else if (q.cnt == `SEE_ACK_DONE) begin
                    d.oe_n = 1'b1;
                    d.cnt = '0;
                    unique case (q.st)
                        see_pkg::ST_DEV: begin
                            if (q.sh[`SEE_RW_BIT]) begin
                                d.st = see_pkg::ST_RDATA;
                                d.oe_n = rd_data[7];
                                d.tx = {rd_data[6:0], 1'b0};
                                d.cnt = 4'h1;
                            end else begin
                                d.st = see_pkg::ST_WADDR;
                            end
                        end
                        see_pkg::ST_WADDR: begin
                            d.addr = q.sh & mask;
                            d.st = see_pkg::ST_WDATA;
                        end
                        see_pkg::ST_WDATA: begin
                            d.page[q.addr[2:0]] = q.sh;
                            d.pmask[q.addr[2:0]] = 1'b1;
                            d.addr = {q.addr[7:3], q.addr[2:0] + 3'h1};
                        end
                        default: begin
                            d.st = see_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
        end

        // ----------------------------------------------------------------
        // Synchronous reset
        // ----------------------------------------------------------------
        if (sys_rst_i) begin
            d = '0;
            d.st = see_pkg::ST_IDLE;
            d.oe_n = `SEE_RST_OE_N;
            d.scl_s1 = `SEE_RST_PIN_HIGH;
            d.scl_s2 = `SEE_RST_PIN_HIGH;
            d.scl_p = `SEE_RST_PIN_HIGH;
            d.sda_s1 = `SEE_RST_PIN_HIGH;
            d.sda_s2 = `SEE_RST_PIN_HIGH;
            d.sda_p = `SEE_RST_PIN_HIGH;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        q <= d;
    end

    assign sda_o = q.sda_val;
    assign sda_oe_n_o = q.oe_n;
    assign busy_o = q.busy;

endmodule : see_top

//--- bench/see_top_monitor.sv
`timescale 1ns/10ps
`include "see_cfg.svh"
// ----------------------------------------------------------------
// Pin checker
// ----------------------------------------------------------------
module see_top_monitor #(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int NV_WRITE_CYCLES = `SEE_NV_WRITE_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic [2:0] hw_address_select_i,
    input wire logic write_guard_pin_i,
    input wire logic busy_o
);
    logic [31:0] busy_n_q;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    always_ff @(posedge ref_clk_i) begin
        busy_n_q <= busy_o ? busy_n_q + 32'h0000_0001 : 32'h0000_0000;
    end
    sequence s_low_run;
        !sda_oe_n_o [*8];
    endsequence
    a_drain_only: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    a_change_low: assert property ($changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i))
        else $error("drive changed with clock high");
    a_drive_stands: assert property ($fell(sda_oe_n_o) |-> s_low_run)
        else $error("low drive too short");
    a_busy_quiet: assert property (busy_o |-> sda_oe_n_o)
        else $error("drive while busy");
    a_guard_block: assert property (write_guard_pin_i [*8] |=> !$rose(busy_o))
        else $error("commit with guard high");
    a_busy_idle: assert property ($rose(busy_o) |-> scl_i && sda_i)
        else $error("commit not after stop");
    a_busy_len: assert property ($fell(busy_o) |->
        busy_n_q + 1 >= NV_WRITE_CYCLES && busy_n_q <= NV_WRITE_CYCLES + 1)
        else $error("commit length wrong");
    a_reset_vals: assert property ($fell(sys_rst_i) |-> sda_oe_n_o && !busy_o)
        else $error("bad state after reset");
endmodule : see_top_monitor

bind see_top see_top_monitor #(
    .LARGE_VARIANT(LARGE_VARIANT),
    .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) i_mon (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .hw_address_select_i(hw_address_select_i),
    .write_guard_pin_i(write_guard_pin_i),
    .busy_o(busy_o)
);

//--- bench/see_host.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bus controller model, clock idles high
// ----------------------------------------------------------------
module see_host (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_n_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end
    task automatic bit_io(input logic b, output logic r);
        #100ns;
        sda_oe_n_o = b;
        #140ns;
        scl_o = 1'b1;
        #120ns;
        r = sda_i;
        #120ns;
        scl_o = 1'b0;
    endtask : bit_io
    task automatic start;
        #107ns;
        sda_oe_n_o = 1'b1;
        #133ns;
        scl_o = 1'b1;
        #240ns;
        sda_oe_n_o = 1'b0;
        #240ns;
        scl_o = 1'b0;
    endtask : start
    task automatic stop;
        #100ns;
        sda_oe_n_o = 1'b0;
        #140ns;
        scl_o = 1'b1;
        #240ns;
        sda_oe_n_o = 1'b1;
        #240ns;
    endtask : stop
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        bit_io(nack, r);
    endtask : rbyte
endmodule : see_host

//--- bench/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module tb_top;
    localparam logic [2:0] SEL = 3'h5;
    localparam logic [2:0] SMALL_SEL = 3'h2;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wg = 1'b0;
    logic [2:0] pins = SEL;
    logic scl, sda, sda_o, oe_n, busy, h_oe_n, k;
    logic oe_n_s, busy_s;
    logic [7:0] exp_q [8];
    logic [7:0] q [8];
    int bad_count = 0;
    int checks = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    assign sda = oe_n & oe_n_s & h_oe_n;
    see_top #(.LARGE_VARIANT(1'b1), .NV_WRITE_CYCLES(40)) i_dut (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n),
        .hw_address_select_i(pins), .write_guard_pin_i(wg), .busy_o(busy));
    see_top #(.LARGE_VARIANT(1'b0), .NV_WRITE_CYCLES(40)) i_dut_small (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n_o(oe_n_s),
        .hw_address_select_i(SMALL_SEL), .write_guard_pin_i(wg), .busy_o(busy_s));
    see_host i_host (.sda_i(sda), .scl_o(scl), .sda_oe_n_o(h_oe_n));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic dev(input logic [2:0] s, input logic rw);
        i_host.start();
        i_host.wbyte({4'hA, s, rw}, k);
    endtask : dev
    task automatic wr(input logic [7:0] a, input int n, input logic [7:0] b);
        dev(SEL, 1'b0);
        `CHK("dev ack", 1'b1, k)
        i_host.wbyte(a, k);
        `CHK("addr ack", 1'b1, k)
        for (int i = 0; i < n; i++) begin
            i_host.wbyte(b + 8'(i), k);
            `CHK("data ack", 1'b1, k)
        end
        i_host.stop();
    endtask : wr
    task automatic rd_page;
        dev(SEL, 1'b0);
        i_host.wbyte(8'hF0, k);
        dev(SEL, 1'b1);
        `CHK("read ack", 1'b1, k)
        for (int i = 0; i < 8; i++) begin
            i_host.rbyte(i == 7, q[i]);
            `CHK("page byte", exp_q[i], q[i])
        end
        i_host.stop();
    endtask : rd_page
    task automatic wait_idle;
        int t;
        t = 0;
        while (busy !== 1'b0 && t < 400) begin
            @(posedge ref_clk_i);
            t++;
        end
        `CHK("commit ends", 1'b0, busy)
        if (t == 400) tally_and_finish();
    endtask : wait_idle
    task automatic t_page;
        wr(8'hF5, 9, 8'h30);
        `CHK("commit runs", 1'b1, busy)
        dev(SEL, 1'b0);
        `CHK("poll refused", 1'b0, k)
        i_host.stop();
        for (int i = 0; i < 9; i++) exp_q[(5 + i) % 8] = 8'h30 + 8'(i);
        wait_idle();
        rd_page();
        wr(8'hF2, 2, 8'h70);
        wait_idle();
        exp_q[2] = 8'h70;
        exp_q[3] = 8'h71;
        rd_page();
        $display("t_page done");
    endtask : t_page
    task automatic t_sel;
        for (int v = 0; v < 8; v++) begin
            @(posedge ref_clk_i);
            #1 pins = 3'(v);
            dev(SEL, 1'b0);
            i_host.stop();
            `CHK("select ack", v == 5, k)
        end
        @(posedge ref_clk_i);
        #1 pins = 3'h0;
        dev(3'h0, 1'b0);
        i_host.stop();
        `CHK("zero select", 1'b1, k)
        @(posedge ref_clk_i);
        #1 pins = SEL;
        i_host.start();
        i_host.wbyte({4'hB, SEL, 1'b0}, k);
        i_host.stop();
        `CHK("bad prefix", 1'b0, k)
        $display("t_sel done");
    endtask : t_sel
    task automatic t_guard;
        @(posedge ref_clk_i);
        #1 wg = 1'b1;
        wr(8'hF0, 3, 8'hE0);
        repeat (4) @(posedge ref_clk_i);
        `CHK("no commit", 1'b0, busy)
        rd_page();
        @(posedge ref_clk_i);
        #1 wg = 1'b0;
        $display("t_guard done");
    endtask : t_guard
    task automatic t_small;
        logic [7:0] v;
        int t;
        dev(SMALL_SEL, 1'b0);
        `CHK("small ack", 1'b1, k)
        i_host.wbyte(8'h85, k);
        i_host.wbyte(8'h5A, k);
        `CHK("small data ack", 1'b1, k)
        i_host.stop();
        `CHK("small commit runs", 1'b1, busy_s)
        t = 0;
        while (busy_s !== 1'b0 && t < 400) begin
            @(posedge ref_clk_i);
            t++;
        end
        `CHK("small commit ends", 1'b0, busy_s)
        if (t == 400) tally_and_finish();
        dev(SMALL_SEL, 1'b0);
        i_host.wbyte(8'h05, k);
        dev(SMALL_SEL, 1'b1);
        i_host.rbyte(1'b1, v);
        i_host.stop();
        `CHK("small addr", 8'h5A, v)
        $display("t_small done");
    endtask : t_small
    initial begin
        repeat (10) @(posedge ref_clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        t_page();
        t_sel();
        t_guard();
        t_small();
        tally_and_finish();
    end
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        bad_count++;
        tally_and_finish();
    end
endmodule : tb_top
